// ---- masmu_defs.vh ----
// constants for the modular add / subtract / multiply unit
// assumes byte addresses on a 12-bit AXI4-Lite register window
`ifndef MASMU_DEFS_VH
`define MASMU_DEFS_VH
`define MASMU_DIG_W      16
`define MASMU_MAX_DIG    16
`define MASMU_T_W        5
`define MASMU_ADDR_W     12
// register offsets
`define MASMU_OFF_CTRL   12'h000
`define MASMU_OFF_FUNC   12'h004
`define MASMU_OFF_STAT   12'h008
// bank windows, one digit per word, index = {sub-register, digit}
`define MASMU_WIN_A      2'h1
`define MASMU_WIN_B      2'h2
`define MASMU_WIN_N      2'h3
// control register fields
`define MASMU_CTRL_A_LSB 0
`define MASMU_CTRL_B_LSB 2
`define MASMU_CTRL_N_LSB 4
`define MASMU_CTRL_M_LSB 8
`define MASMU_CTRL_RST   12'h000
// status register bits
`define MASMU_STAT_BUSY  0
`define MASMU_STAT_DONE  1
`define MASMU_STAT_ERR   2
// entry addresses
`define MASMU_ENT_ADD    10'h008
`define MASMU_ENT_SUB    10'h009
`define MASMU_ENT_MUL    10'h00A
// least digit-count settings
`define MASMU_MIN_ADDSUB 4'h3
`define MASMU_MIN_MUL    4'h4
// inverse iterations for 1/n0 mod 2^16, negated when m is formed
`define MASMU_INV_ITER   4'h4
// bus answers
`define MASMU_RESP_OK    2'h0
`define MASMU_RESP_ERR   2'h2
`endif

// ---- masmu_adsub.v ----
// twin carry chains for one digit of modular add or subtract
// assumes the caller holds carries/borrows between digits
`include "masmu_defs.vh"
module masmu_adsub
(
  // control
  input  wire                    op_sub,
  // digits
  input  wire [`MASMU_DIG_W-1:0] x,
  input  wire [`MASMU_DIG_W-1:0] y,
  input  wire [`MASMU_DIG_W-1:0] z,
  input  wire                    cin1,
  input  wire                    cin2,
  // results
  output wire [`MASMU_DIG_W-1:0] s1,
  output wire                    c1o,
  output wire [`MASMU_DIG_W-1:0] s2,
  output wire                    c2o
);
  wire [`MASMU_DIG_W:0] r1;
  wire [`MASMU_DIG_W:0] r2;
  // chain one: x+y or x-y; chain two corrects by the modulus
  assign r1 = op_sub ? ({1'b0, x} - {1'b0, y} - {16'h0000, cin1})
                     : ({1'b0, x} + {1'b0, y} + {16'h0000, cin1});
  assign r2 = op_sub ? ({1'b0, r1[15:0]} + {1'b0, z} + {16'h0000, cin2})
                     : ({1'b0, r1[15:0]} - {1'b0, z} - {16'h0000, cin2});
  assign s1  = r1[15:0];
  assign c1o = r1[16];
  assign s2  = r2[15:0];
  assign c2o = r2[16];
endmodule // masmu_adsub

// ---- masmu_mac.v ----
// one digit multiply-accumulate: t + x*y + c
// worst case (2^16-1)^2 + 2(2^16-1) fits in 32 bits, no overflow
`include "masmu_defs.vh"
module masmu_mac
(
  // operands
  input  wire [`MASMU_DIG_W-1:0]   t,
  input  wire [`MASMU_DIG_W-1:0]   x,
  input  wire [`MASMU_DIG_W-1:0]   y,
  input  wire [`MASMU_DIG_W-1:0]   c,
  // result
  output wire [2*`MASMU_DIG_W-1:0] r
);
  assign r = x * y + {16'h0000, t} + {16'h0000, c};
endmodule // masmu_mac

// ---- masmu_top.v ----
// modular add, subtract and montgomery multiply over 16-bit digits
// assumes one clock, AXI4-Lite master, odd modulus for the multiply
`include "masmu_defs.vh"
module masmu_top
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write address
  input  wire [11:0] awaddr,
  input  wire        awvalid,
  output reg         awready,
  // write data
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // read address
  input  wire [11:0] araddr,
  input  wire        arvalid,
  output reg         arready,
  // read data
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // status
  output reg         func_done
);
  localparam S_IDLE = 9'h001;
  localparam S_INV  = 9'h002;
  localparam S_ADD  = 9'h004;
  localparam S_MA   = 9'h008;
  localparam S_MC   = 9'h010;
  localparam S_MB   = 9'h020;
  localparam S_MT   = 9'h040;
  localparam S_FIN  = 9'h080;
  localparam S_WB   = 9'h100;
  localparam D_CTRL = 3'h0;
  localparam D_FUNC = 3'h1;
  localparam D_STAT = 3'h2;
  localparam D_A    = 3'h3;
  localparam D_B    = 3'h4;
  localparam D_N    = 3'h5;
  localparam D_BAD  = 3'h7;

  function [2:0] dec;
    input [11:0] ad;
    begin
      if (ad[1:0] != 2'h0)
        dec = D_BAD;
      else if (ad == `MASMU_OFF_CTRL)
        dec = D_CTRL;
      else if (ad == `MASMU_OFF_FUNC)
        dec = D_FUNC;
      else if (ad == `MASMU_OFF_STAT)
        dec = D_STAT;
      else if (ad[9:8] != 2'h0)
        dec = D_BAD;
      else if (ad[11:10] == `MASMU_WIN_A)
        dec = D_A;
      else if (ad[11:10] == `MASMU_WIN_B)
        dec = D_B;
      else if (ad[11:10] == `MASMU_WIN_N)
        dec = D_N;
      else
        dec = D_BAD;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer      q;
    begin
      merge = old;
      for (q = 0; q < 4; q = q + 1)
        if (st[q])
          merge[q*8 +: 8] = nw[q*8 +: 8];
    end
  endfunction

  function [15:0] mlo;
    input [15:0] p;
    input [15:0] q;
    reg   [31:0] pr;
    begin
      pr  = p * q;
      mlo = pr[15:0];
    end
  endfunction

  // four sub-registers per bank, one digit per entry
  reg  [15:0] a_mem [0:63];
  reg  [15:0] b_mem [0:63];
  reg  [15:0] n_mem [0:63];
  reg  [15:0] t_mem [0:17];
  reg  [15:0] u_mem [0:15];

  reg  [11:0] awaddr_ff;
  reg         aw_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         w_ff;
  reg  [11:0] ctrl_ff;
  reg  [8:0]  state_ff;
  reg  [1:0]  op_ff;
  reg  [3:0]  j_ff;
  reg  [3:0]  i_ff;
  reg         c1_ff;
  reg         c2_ff;
  reg  [15:0] mc_ff;
  reg  [15:0] m_ff;
  reg  [15:0] x_ff;
  reg         usel_ff;
  reg         err_ff;
  reg  [31:0] rd_word;
  integer     k;

  wire [1:0]  asel = ctrl_ff[`MASMU_CTRL_A_LSB +: 2];
  wire [1:0]  bsel = ctrl_ff[`MASMU_CTRL_B_LSB +: 2];
  wire [1:0]  nsel = ctrl_ff[`MASMU_CTRL_N_LSB +: 2];
  wire [3:0]  msz  = ctrl_ff[`MASMU_CTRL_M_LSB +: 4];
  wire [4:0]  dtop = {1'b0, msz} + 5'h01;
  wire        busy = ~state_ff[0];
  wire        last = (j_ff == msz);
  wire        wr_en = aw_ff & w_ff & ~bvalid;
  wire [2:0]  wdec = dec(awaddr_ff);
  wire [2:0]  rdec = dec(araddr);
  // writes other than status are refused while busy so pointers stay put mid-function
  wire        wr_ok = (wdec != D_BAD) & (~busy | (wdec == D_STAT));
  wire        wr_go = wr_en & wr_ok;
  wire [31:0] wmask = merge(32'h00000000, wdata_ff, wstrb_ff);
  wire [5:0]  widx = awaddr_ff[7:2];
  // byte-lane merges, cut to the register width where they land
  wire [31:0] nxt_ctrl   = merge({20'h00000, ctrl_ff}, wdata_ff, wstrb_ff);
  wire [31:0] nxt_a_word = merge({16'h0000, a_mem[widx]}, wdata_ff,
                                 wstrb_ff);
  wire [31:0] nxt_b_word = merge({16'h0000, b_mem[widx]}, wdata_ff,
                                 wstrb_ff);
  wire [31:0] nxt_n_word = merge({16'h0000, n_mem[widx]}, wdata_ff,
                                 wstrb_ff);
  wire [9:0]  entry = wdata_ff[9:0];
  wire        start = wr_go & (wdec == D_FUNC) & (wstrb_ff[1:0] == 2'h3);
  wire        fin = state_ff[7];

  // digit datapath operands
  wire [15:0] ad_x = fin ? t_mem[j_ff] : a_mem[{asel, j_ff}];
  wire [15:0] ad_y = fin ? 16'h0000 : b_mem[{bsel, j_ff}];
  wire [15:0] n_j  = n_mem[{nsel, j_ff}];
  wire [15:0] s1;
  wire [15:0] s2;
  wire        c1o;
  wire        c2o;
  wire        mb = state_ff[5];
  wire [15:0] mac_x = mb ? m_ff : a_mem[{asel, j_ff}];
  wire [15:0] mac_y = mb ? n_j : b_mem[{bsel, i_ff}];
  wire [15:0] mac_c = (mb && j_ff == 4'h0) ? 16'h0000 : mc_ff;
  wire [31:0] mac_r;
  wire [16:0] top_s = {1'b0, t_mem[dtop]} + {1'b0, mc_ff};
  wire [4:0]  dm1 = dtop - 5'h01;
  wire [4:0]  dp1 = dtop + 5'h01;

  // the multiply's final subtract of N also runs through the add/subtract chains
  masmu_adsub u_adsub
  (
    .op_sub (op_ff == 2'h1 && !fin),
    .x      (ad_x),
    .y      (ad_y),
    .z      (n_j),
    .cin1   (c1_ff),
    .cin2   (c2_ff),
    .s1     (s1),
    .c1o    (c1o),
    .s2     (s2),
    .c2o    (c2o)
  );

  masmu_mac u_mac
  (
    .t (t_mem[j_ff]),
    .x (mac_x),
    .y (mac_y),
    .c (mac_c),
    .r (mac_r)
  );

  // bus handshakes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff  <= 32'h00000000;
      wstrb_ff  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `MASMU_RESP_OK;
      arready   <= 1'b1;
      rvalid    <= 1'b0;
      rresp     <= `MASMU_RESP_OK;
      rdata     <= 32'h00000000;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_ff     <= 1'b1;
        awaddr_ff <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_ff     <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
        wready   <= 1'b0;
      end
      if (wr_en)
      begin
        aw_ff  <= 1'b0;
        w_ff   <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_ok ? `MASMU_RESP_OK : `MASMU_RESP_ERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= (rdec == D_BAD) ? `MASMU_RESP_ERR : `MASMU_RESP_OK;
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  always @*
  begin
    rd_word = 32'h00000000;
    case (rdec)
      D_CTRL: rd_word = {20'h00000, ctrl_ff};
      D_STAT: rd_word = {29'h00000000, err_ff, func_done, busy};
      D_A:    rd_word = {16'h0000, a_mem[araddr[7:2]]};
      D_B:    rd_word = {16'h0000, b_mem[araddr[7:2]]};
      D_N:    rd_word = {16'h0000, n_mem[araddr[7:2]]};
      default: rd_word = 32'h00000000;
    endcase
  end

  // host bank loads; refused while busy so they never meet write-back
  always @(posedge aclk)
  begin
    if (wr_go && wdec == D_A)
      a_mem[widx] <= nxt_a_word[15:0];
    if (wr_go && wdec == D_N)
      n_mem[widx] <= nxt_n_word[15:0];
    if (wr_go && wdec == D_B)
      b_mem[widx] <= nxt_b_word[15:0];
    // result lands over the selected B sub-register only
    else if (state_ff == S_WB)
      b_mem[{bsel, j_ff}] <= usel_ff ? u_mem[j_ff] : t_mem[j_ff];
  end

  // scratch vectors
  always @(posedge aclk)
  begin
    if (start)
    begin
      for (k = 0; k < 18; k = k + 1)
        t_mem[k] <= 16'h0000;
    end
    case (state_ff)
      S_ADD:
      begin
        t_mem[j_ff] <= s1;
        u_mem[j_ff] <= s2;
      end
      S_FIN:
        u_mem[j_ff] <= s2;
      S_MA:
        t_mem[j_ff] <= mac_r[15:0];
      S_MC:
      begin
        t_mem[dtop] <= top_s[15:0];
        t_mem[dp1]  <= {15'h0000, top_s[16]};
      end
      S_MB:
        if (j_ff != 4'h0)
          t_mem[j_ff - 4'h1] <= mac_r[15:0];
      S_MT:
      begin
        t_mem[dm1]  <= top_s[15:0];
        t_mem[dtop] <= t_mem[dp1] + {15'h0000, top_s[16]};
        t_mem[dp1]  <= 16'h0000;
      end
      default:
        ;
    endcase
  end

  // sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff   <= `MASMU_CTRL_RST;
      state_ff  <= S_IDLE;
      op_ff     <= 2'h0;
      j_ff      <= 4'h0;
      i_ff      <= 4'h0;
      c1_ff     <= 1'b0;
      c2_ff     <= 1'b0;
      mc_ff     <= 16'h0000;
      m_ff      <= 16'h0000;
      x_ff      <= 16'h0000;
      usel_ff   <= 1'b0;
      err_ff    <= 1'b0;
      func_done <= 1'b0;
    end
    else
    begin
      // pointers and digit count latched from the control word
      if (wr_go && wdec == D_CTRL)
        ctrl_ff <= nxt_ctrl[11:0] & 12'hF3F;
      if (wr_go && wdec == D_STAT)
      begin
        if (wmask[`MASMU_STAT_DONE])
          func_done <= 1'b0;
        if (wmask[`MASMU_STAT_ERR])
          err_ff <= 1'b0;
      end
      case (state_ff)
        S_IDLE:
          if (start)
          begin
            func_done <= 1'b0;
            err_ff    <= 1'b0;
            j_ff      <= 4'h0;
            i_ff      <= 4'h0;
            c1_ff     <= 1'b0;
            c2_ff     <= 1'b0;
            mc_ff     <= 16'h0000;
            x_ff      <= n_mem[{nsel, 4'h0}];
            if (entry == `MASMU_ENT_ADD && msz >= `MASMU_MIN_ADDSUB)
            begin
              op_ff    <= 2'h0;
              state_ff <= S_ADD;
            end
            else if (entry == `MASMU_ENT_SUB &&
                     msz >= `MASMU_MIN_ADDSUB)
            begin
              op_ff    <= 2'h1;
              state_ff <= S_ADD;
            end
            else if (entry == `MASMU_ENT_MUL && msz >= `MASMU_MIN_MUL)
            begin
              op_ff    <= 2'h2;
              state_ff <= S_INV;
            end
            else
            begin
              err_ff    <= 1'b1;
              func_done <= 1'b1;
            end
          end
        S_INV:
        begin
          // newton step doubles the correct low bits of 1/n0
          x_ff <= mlo(x_ff, 16'h0002 - mlo(n_mem[{nsel, 4'h0}], x_ff));
          j_ff <= j_ff + 4'h1;
          if (j_ff == `MASMU_INV_ITER - 4'h1)
          begin
            j_ff     <= 4'h0;
            state_ff <= S_MA;
          end
        end
        S_ADD:
        begin
          c1_ff <= c1o;
          c2_ff <= c2o;
          j_ff  <= j_ff + 4'h1;
          if (last)
          begin
            // subtract corrects by N only on a final borrow
            if (op_ff == 2'h1)
              usel_ff <= c1o;
            // add takes sum - N when the sum reaches N
            else
              usel_ff <= c1o | ~c2o;
            j_ff     <= 4'h0;
            state_ff <= S_WB;
          end
        end
        S_MA:
        begin
          mc_ff <= mac_r[31:16];
          j_ff  <= j_ff + 4'h1;
          if (last)
            state_ff <= S_MC;
        end
        S_MC:
        begin
          m_ff     <= 16'h0000 - mlo(t_mem[0], x_ff);
          mc_ff    <= 16'h0000;
          j_ff     <= 4'h0;
          state_ff <= S_MB;
        end
        S_MB:
        begin
          mc_ff <= mac_r[31:16];
          j_ff  <= j_ff + 4'h1;
          if (last)
            state_ff <= S_MT;
        end
        S_MT:
        begin
          mc_ff <= 16'h0000;
          j_ff  <= 4'h0;
          i_ff  <= i_ff + 4'h1;
          if (i_ff == msz)
          begin
            c2_ff    <= 1'b0;
            state_ff <= S_FIN;
          end
          else
            state_ff <= S_MA;
        end
        S_FIN:
        begin
          c2_ff <= c2o;
          j_ff  <= j_ff + 4'h1;
          if (last)
          begin
            // one conditional subtract leaves the product below N
            usel_ff  <= (t_mem[dtop] != 16'h0000) | ~c2o;
            j_ff     <= 4'h0;
            state_ff <= S_WB;
          end
        end
        S_WB:
        begin
          j_ff <= j_ff + 4'h1;
          if (last)
          begin
            // set after the clear above, so it wins
            func_done <= 1'b1;
            state_ff  <= S_IDLE;
          end
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // masmu_top

// ---- masmu_props.sv ----
// checker for the unit's bus answers and done flag
// assumes it is bound to masmu_top, one clock domain
`include "masmu_defs.vh"
module masmu_props
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // write side
  input wire [11:0] awaddr,
  input wire        awvalid,
  input wire        awready,
  input wire [31:0] wdata,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  // read side
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  // status
  input wire        func_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire both_w = awvalid && awready && wvalid && wready;
  wire quiet = awready && wready && !awvalid && !wvalid;
  a_reset_idle: assert property ($rose(aresetn) |->
    awready && arready && !bvalid && !rvalid && !func_done)
    else $error("outputs not idle after reset");
  a_b_timing: assert property (both_w |=> !awready && !bvalid ##1 bvalid)
    else $error("write answer late or early");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_r_timing: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one cycle later");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_done_stays: assert property (func_done && quiet |=> func_done)
    else $error("done fell without a write");
  a_add_done: assert property (both_w && awaddr == `MASMU_OFF_FUNC
    && wdata[9:0] == `MASMU_ENT_ADD |-> ##[4:700] func_done)
    else $error("add never completed");
endmodule // masmu_props
bind masmu_top masmu_props u_props (.aclk(aclk), .aresetn(aresetn),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .func_done(func_done));

// ---- masmu_host.sv ----
// host processor model: an AXI4-Lite master with one write and one read
// assumes the bench's watchdog cuts short any wait that never ends
module masmu_host
(
  // clock
  input  wire         aclk,
  // write side
  output logic [11:0] awaddr,
  output logic        awvalid,
  input  wire         awready,
  output logic [31:0] wdata,
  output logic [3:0]  wstrb,
  output logic        wvalid,
  input  wire         wready,
  output logic        bready,
  input  wire         bvalid,
  // read side
  output logic [11:0] araddr,
  output logic        arvalid,
  input  wire         arready,
  output logic        rready,
  input  wire         rvalid,
  input  wire  [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic pa;
    logic pd;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    pa = 1'b1;
    pd = 1'b1;
    while (pa || pd)
    begin
      @(posedge aclk);
      if (pa && awready)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (pd && wready)
      begin
        pd = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask
endmodule // masmu_host

// ---- masmu_tb.sv ----
// self-checking bench for modular add, subtract and multiply
// assumes masmu_host as master and masmu_props bound to the top
`include "masmu_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk;
  logic        aresetn;
  wire  [11:0] awaddr, araddr;
  wire  [31:0] wdata, rdata;
  wire  [3:0]  wstrb;
  wire  [1:0]  bresp, rresp;
  wire         awvalid, awready, wvalid, wready, bvalid, bready;
  wire         arvalid, arready, rvalid, rready, func_done;
  int          n_errors;
  int          cmp_count;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  logic [65:0] e;
  masmu_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .func_done(func_done));
  masmu_host u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bready(bready), .bvalid(bvalid), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rready(rready), .rvalid(rvalid),
    .rdata(rdata));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic close_out();
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] x, g, m);
    if (m != 32'h0)
    begin
      cmp_count++;
      if ((g & m) !== (x & m))
      begin
        n_errors++;
        $display("CHECK FAILED at %0t: exp %h got %h", $time, x & m, g & m);
      end
    end
  endtask
  // oldest note pairs with each answer
  always @(posedge aclk)
  begin
    if (bvalid && bready && bq.size() > 0)
      check({30'h0, bq.pop_front()}, {30'h0, bresp}, 32'h3);
    if (rvalid && rready && rq.size() > 0)
    begin
      e = rq.pop_front();
      check({30'h0, e[65:64]}, {30'h0, rresp}, 32'h3);
      check(e[31:0], rdata, e[63:32]);
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    u_host.wr(a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, m,
                    input logic [1:0] r);
    logic [31:0] d;
    rq.push_back({r, m, x});
    u_host.rd(a, d);
  endtask
  task automatic wait_done();
    logic [31:0] d;
    int k;
    d = 32'h0;
    for (k = 0; k < 300 && !d[1]; k++)
    begin
      rq.push_back(66'h0);
      u_host.rd(`MASMU_OFF_STAT, d);
    end
    check(32'h2, d, 32'h2);
  endtask
  // one digit a word, bank and pointer in the address
  task automatic vec(input logic [1:0] w, p, input logic [191:0] v,
                     input int nd, input bit chk);
    logic [11:0] a;
    for (int i = 0; i < nd; i++)
    begin
      a = {w, 2'h0, p, 4'(i), 2'h0};
      if (chk)
        rd(a, {16'h0, v[16*i +: 16]}, 32'hFFFFFFFF, `MASMU_RESP_OK);
      else
        wr(a, {16'h0, v[16*i +: 16]}, `MASMU_RESP_OK);
    end
  endtask
  // bit-serial reference, one halving per bit of R
  function automatic logic [191:0] mont(input logic [191:0] a, b, n,
                                        input int k);
    logic [191:0] t;
    t = '0;
    for (int i = 0; i < k; i++)
    begin
      t = t + (a[i] ? b : 192'h0);
      if (t[0])
        t = t + n;
      t = t >> 1;
    end
    return (t >= n) ? t - n : t;
  endfunction
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
  initial
  begin
    logic [191:0] a, b, n, r;
    logic [1:0] pa, pb, pn;
    int nd;
    n_errors = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    void'($urandom(48333));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MASMU_OFF_CTRL, 32'h0, 32'hFFFFFFFF, `MASMU_RESP_OK);
    rd(`MASMU_OFF_STAT, 32'h0, 32'h7, `MASMU_RESP_OK);
    rd(12'h00C, 32'h0, 32'hFFFFFFFF, `MASMU_RESP_ERR);
    wr(12'h00C, 32'h0, `MASMU_RESP_ERR);
    for (int op = 0; op < 3; op++)
    begin
      nd = (op == 2) ? 5 : 4;
      {pa, pb, pn} = 6'($urandom);
      n = {$urandom, $urandom, $urandom};
      n &= (192'h1 << (16 * nd)) - 192'h1;
      n[16*nd-1] = 1'b1;
      n[0] = 1'b1;
      a = {$urandom, $urandom, $urandom} % n;
      b = {$urandom, $urandom, $urandom} % n;
      // borrow path: subtrahend larger
      if (op == 1 && a > b)
        {a, b} = {b, a};
      r = (op == 0) ? (a + b) % n : (op == 1) ? (a + n - b) % n
        : mont(a, b, n, 16 * nd);
      vec(`MASMU_WIN_A, pa, a, nd, 0);
      vec(`MASMU_WIN_B, pb, b, nd, 0);
      vec(`MASMU_WIN_N, pn, n, nd, 0);
      // pointers and digit count before the start
      wr(`MASMU_OFF_CTRL, {20'h0, 4'(nd - 1), 2'h0, pn, pb, pa}, 0);
      wr(`MASMU_OFF_FUNC, {22'h0, `MASMU_ENT_ADD + 10'(op)}, 0);
      // busy unit refuses a control write
      if (op == 2)
        wr(`MASMU_OFF_CTRL, 32'h0, `MASMU_RESP_ERR);
      wait_done();
      check(32'h1, {31'h0, func_done}, 32'h1);
      rd(`MASMU_OFF_STAT, 32'h2, 32'h7, 0);
      vec(`MASMU_WIN_B, pb, r, nd, 1);
      vec(`MASMU_WIN_A, pa, a, nd, 1);
    end
    // too few digits, or an unknown entry, ends with error
    for (int k = 0; k < 4; k++)
    begin
      wr(`MASMU_OFF_CTRL, (k < 2) ? 32'h200 : 32'h300, 0);
      wr(`MASMU_OFF_FUNC, {22'h0, `MASMU_ENT_ADD + 10'(k)}, 0);
      rd(`MASMU_OFF_STAT, 32'h6, 32'h7, 0);
      wr(`MASMU_OFF_STAT, 32'h6, 0);
      check(32'h0, {31'h0, func_done}, 32'h1);
      rd(`MASMU_OFF_STAT, 32'h0, 32'h7, 0);
    end
    close_out();
  end
endmodule // tb
